/* File: core/pswi_pkg.sv */
package pswi_pkg;

  // ----------------------------------------------------------------
  // Clock and port counts
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int NPORT  = 7;
  localparam int NCU    = 5;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int APD_SHORT_MS  = 2700;
  localparam int APD_LONG_MS   = 5400;
  localparam int APD_SHORT_CYC = APD_SHORT_MS * (CLK_HZ / 1000);
  localparam int APD_LONG_CYC  = APD_LONG_MS * (CLK_HZ / 1000);
  localparam int APD_CW        = 27;
  localparam int CHECK_US      = 100;
  localparam int CHECK_CYC     = CHECK_US * (CLK_HZ / 1_000_000);
  localparam int PLL_US        = 10;
  localparam int PLL_CYC       = PLL_US * (CLK_HZ / 1_000_000);
  localparam int TICK_US       = 1;
  localparam int TICK_CYC      = TICK_US * (CLK_HZ / 1_000_000);
  localparam int TICK_W        = 5;
  localparam int STRAP_WAIT    = 3;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PWR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_LPI_EN     = 8'h04;
  localparam logic [7:0] ADDR_INT_EN     = 8'h08;
  localparam logic [7:0] ADDR_HOLD_MGMT  = 8'h10;
  localparam logic [7:0] ADDR_HOLD_P5    = 8'h14;
  localparam logic [7:0] ADDR_INT_STAT   = 8'h18;
  localparam logic [7:0] ADDR_LPI_THR    = 8'h1c;
  localparam logic [7:0] ADDR_LPI_SLEEP  = 8'h20;
  localparam logic [7:0] ADDR_LPI_TIMES  = 8'h24;
  localparam logic [7:0] ADDR_SC_CTRL    = 8'h28;
  localparam logic [7:0] ADDR_STATUS     = 8'h2c;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int PWR_LONG_BIT   = 5;
  localparam int PWR_DLL_BIT    = 6;
  localparam int INT_WAKE_LSB   = 8;
  localparam int SC_THR_LSB     = 8;
  localparam int SC_LINK_BIT    = 16;
  localparam int SC_NOW_BIT     = 17;
  localparam logic [15:0] INT_EN_MASK = 16'h607f;
  localparam logic [15:0] RST_16      = 16'h0000;
  localparam logic [31:0] RST_32      = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {APD_ON, APD_DOWN, APD_CHECK} pswi_apd_t;
  typedef enum logic [1:0] {LPI_ACTIVE, LPI_DELAY, LPI_SLEEP, LPI_WAKE} pswi_lpi_t;
  typedef enum logic [1:0] {DG_RUN, DG_DEEP, DG_WAKE} pswi_deep_t;

endpackage : pswi_pkg

/* File: core/pswi_top.sv */
`timescale 1ns/1ps
`default_nettype none

module pswi_top #(
  parameter int APD_SHORT_CYC = pswi_pkg::APD_SHORT_CYC,
  parameter int APD_LONG_CYC  = pswi_pkg::APD_LONG_CYC
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // PHY pins
  input  wire logic [6:0]  link_up_pin,
  input  wire logic [4:0]  energy_pin,
  input  wire logic        uc_en_strap,
  output logic [4:0]       phy_power_down,
  output logic             phy_supply_on,
  output logic             pll_power_on,
  output logic             autoneg_restart,
  // MAC and queue side
  input  wire logic [6:0]  txq_pending,
  input  wire logic [7:0]  buf_occupancy,
  input  wire logic [6:0]  lp_lpi_cap,
  input  wire logic [1:0]  port_gmii,
  output logic [6:0]       tx_lpi,
  output logic [6:0]       tx_sleep_sym,
  output logic [6:0]       tx_wake_sym,
  output logic [1:0]       tx_hold,
  // Cable diagnostics
  output logic [4:0]       diag_start,
  input  wire logic [4:0]  diag_done,
  input  wire logic [7:0]  diag_len,
  output logic [4:0]       rx_power_low,
  // Interrupt
  output logic             irq
);

  localparam int DG_WIN = pswi_pkg::PLL_CYC + 2;

  // ----------------------------------------------------------------
  // Input synchronisers and strap capture
  // ----------------------------------------------------------------
  logic [6:0] link_s1_q, link_q, link_prev_q;
  logic [4:0] energy_s1_q, energy_q;
  logic       strap_s1_q, strap_s2_q, uc_en_q;
  logic [1:0] strap_cnt_q;

  always_ff @(posedge aclk) begin
    link_s1_q   <= link_up_pin;
    link_q      <= link_s1_q;
    energy_s1_q <= energy_pin;
    energy_q    <= energy_s1_q;
    strap_s1_q  <= uc_en_strap;
    strap_s2_q  <= strap_s1_q;
  end

  // The strap is taken only once the synchroniser holds real pin values.
  // strap sampled for STRAP_WAIT cycles after reset, then held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_cnt_q <= 2'h0;
      uc_en_q     <= 1'b0;
      link_prev_q <= 7'h00;
    end else begin
      link_prev_q <= link_q;
      if (strap_cnt_q != 2'(pswi_pkg::STRAP_WAIT)) begin
        strap_cnt_q <= strap_cnt_q + 2'h1;
        uc_en_q     <= strap_s2_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [15:0] ctrl_q, lpi_en_q, int_en_q, stat_q, sc_q;
  logic [15:0] hold_time_q [2];
  logic [7:0]  lpi_thr_q;
  logic [31:0] sleep_q, times_q, rdata_d;
  logic        wr_fire, rd_fire, sc_now;
  pswi_pkg::pswi_deep_t dg_q;

  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) r[8*b +: 8] = d[8*b +: 8];
    end
    return r;
  endfunction : wmerge

  function automatic logic mapped(input logic [7:0] a);
    logic m;
    m = (a[1:0] == 2'h0) && (a <= pswi_pkg::ADDR_STATUS) && (a != 8'h0c) && (a != 8'h10 - 8'h4);
    return m && (a != 8'h0c);
  endfunction : mapped

  // Address and data are taken together, so the master may offer them in either order.
  assign wr_fire = awvalid && wvalid && !bvalid;
  assign awready = wr_fire;
  assign wready  = wr_fire;
  assign rd_fire = arvalid && !rvalid;
  assign arready = !rvalid;
  assign sc_now  = wr_fire && (awaddr == pswi_pkg::ADDR_SC_CTRL) && wstrb[2]
                   && wdata[pswi_pkg::SC_NOW_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= pswi_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp  <= mapped(awaddr) ? pswi_pkg::RESP_OKAY : pswi_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q         <= pswi_pkg::RST_16;
      lpi_en_q       <= pswi_pkg::RST_16;
      int_en_q       <= pswi_pkg::RST_16;
      hold_time_q[0] <= pswi_pkg::RST_16;
      hold_time_q[1] <= pswi_pkg::RST_16;
      lpi_thr_q      <= 8'h00;
      sleep_q        <= pswi_pkg::RST_32;
      times_q        <= pswi_pkg::RST_32;
      sc_q           <= pswi_pkg::RST_16;
    end else if (wr_fire) begin
      case (awaddr)
        pswi_pkg::ADDR_PWR_CTRL:  ctrl_q <= 16'(wmerge({16'h0, ctrl_q}, wdata, wstrb));
        pswi_pkg::ADDR_LPI_EN:    lpi_en_q <= 16'(wmerge({16'h0, lpi_en_q}, wdata, wstrb));
        pswi_pkg::ADDR_INT_EN:    int_en_q <= 16'(wmerge({16'h0, int_en_q}, wdata, wstrb))
                                              & pswi_pkg::INT_EN_MASK;
        pswi_pkg::ADDR_HOLD_P5:   hold_time_q[0] <= 16'(wmerge({16'h0, hold_time_q[0]}, wdata,
                                                               wstrb));
        pswi_pkg::ADDR_HOLD_MGMT: hold_time_q[1] <= 16'(wmerge({16'h0, hold_time_q[1]}, wdata,
                                                               wstrb));
        pswi_pkg::ADDR_LPI_THR:   lpi_thr_q <= 8'(wmerge({24'h0, lpi_thr_q}, wdata, wstrb));
        pswi_pkg::ADDR_LPI_SLEEP: sleep_q <= wmerge(sleep_q, wdata, wstrb);
        pswi_pkg::ADDR_LPI_TIMES: times_q <= wmerge(times_q, wdata, wstrb);
        pswi_pkg::ADDR_SC_CTRL:   sc_q <= 16'(wmerge({16'h0, sc_q}, wdata, wstrb));
        default: ;
      endcase
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (araddr)
      pswi_pkg::ADDR_PWR_CTRL:  rdata_d = {16'h0, ctrl_q};
      pswi_pkg::ADDR_LPI_EN:    rdata_d = {16'h0, lpi_en_q};
      pswi_pkg::ADDR_INT_EN:    rdata_d = {16'h0, int_en_q};
      pswi_pkg::ADDR_HOLD_MGMT: rdata_d = {16'h0, hold_time_q[1]};
      pswi_pkg::ADDR_HOLD_P5:   rdata_d = {16'h0, hold_time_q[0]};
      pswi_pkg::ADDR_INT_STAT:  rdata_d = {16'h0, stat_q};
      pswi_pkg::ADDR_LPI_THR:   rdata_d = {24'h0, lpi_thr_q};
      pswi_pkg::ADDR_LPI_SLEEP: rdata_d = sleep_q;
      pswi_pkg::ADDR_LPI_TIMES: rdata_d = times_q;
      pswi_pkg::ADDR_SC_CTRL:   rdata_d = {16'h0, sc_q};
      pswi_pkg::ADDR_STATUS:    rdata_d = {7'h00, tx_hold, tx_lpi, 7'h00, uc_en_q,
                                           dg_q == pswi_pkg::DG_DEEP, link_q};
      default:                  rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= pswi_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      rvalid <= 1'b1;
      rdata  <= rdata_d;
      rresp  <= mapped(araddr) ? pswi_pkg::RESP_OKAY : pswi_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  axi_wr_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("Write response dropped before it was taken.");

  // ----------------------------------------------------------------
  // Auto power-down per copper port
  // ----------------------------------------------------------------
  logic [pswi_pkg::APD_CW-1:0] apd_reload;
  assign apd_reload = ctrl_q[pswi_pkg::PWR_LONG_BIT] ? pswi_pkg::APD_CW'(APD_LONG_CYC)
                                                     : pswi_pkg::APD_CW'(APD_SHORT_CYC);

  for (genvar i = 0; i < pswi_pkg::NCU; i++) begin : g_apd
    pswi_pkg::pswi_apd_t          st_q;
    logic [pswi_pkg::APD_CW-1:0]  cnt_q;

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        st_q  <= pswi_pkg::APD_ON;
        cnt_q <= '0;
      end else begin
        case (st_q)
          pswi_pkg::APD_ON: begin
            if (ctrl_q[i] && !link_q[i]) begin
              st_q  <= pswi_pkg::APD_DOWN;
              cnt_q <= apd_reload;
            end
          end
          pswi_pkg::APD_DOWN: begin
            if (!ctrl_q[i]) begin
              st_q <= pswi_pkg::APD_ON;
            end else if (cnt_q == '0) begin
              st_q  <= pswi_pkg::APD_CHECK;
              cnt_q <= pswi_pkg::APD_CW'(pswi_pkg::CHECK_CYC);
            end else begin
              cnt_q <= cnt_q - 1'b1;
            end
          end
          pswi_pkg::APD_CHECK: begin
            if (link_q[i] || energy_q[i] || !ctrl_q[i]) begin
              st_q <= pswi_pkg::APD_ON;
            end else if (cnt_q == '0) begin
              st_q  <= pswi_pkg::APD_DOWN;
              cnt_q <= apd_reload;
            end else begin
              cnt_q <= cnt_q - 1'b1;
            end
          end
          default: st_q <= pswi_pkg::APD_ON;
        endcase
      end
    end

    assign phy_power_down[i] = (st_q == pswi_pkg::APD_DOWN) || (dg_q != pswi_pkg::DG_RUN);
  end

  apd_enter_a: assert property (@(posedge aclk) disable iff (!aresetn)
    g_apd[0].st_q == pswi_pkg::APD_ON && ctrl_q[0] && !link_q[0]
    |=> g_apd[0].st_q == pswi_pkg::APD_DOWN && phy_power_down[0])
    else $error("Port 0 did not power down on link loss.");

  apd_check_a: assert property (@(posedge aclk) disable iff (!aresetn)
    g_apd[0].st_q == pswi_pkg::APD_CHECK && link_q[0] |=> g_apd[0].st_q == pswi_pkg::APD_ON)
    else $error("Port 0 did not wake on link at check.");

  // ----------------------------------------------------------------
  // Deep power-down sequencing
  // ----------------------------------------------------------------
  logic [7:0] dg_cnt_q;
  logic       deep_ok;

  assign deep_ok = uc_en_q && (&ctrl_q[pswi_pkg::NCU-1:0]) && ctrl_q[pswi_pkg::PWR_DLL_BIT]
                   && !(|link_q[pswi_pkg::NCU-1:0]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dg_q            <= pswi_pkg::DG_RUN;
      dg_cnt_q        <= 8'h00;
      autoneg_restart <= 1'b0;
    end else begin
      autoneg_restart <= 1'b0;
      case (dg_q)
        pswi_pkg::DG_RUN:  if (deep_ok && !(|energy_q)) dg_q <= pswi_pkg::DG_DEEP;
        pswi_pkg::DG_DEEP: begin
          if (|energy_q) begin
            dg_q     <= pswi_pkg::DG_WAKE;
            dg_cnt_q <= 8'(pswi_pkg::PLL_CYC);
          end
        end
        pswi_pkg::DG_WAKE: begin
          if (dg_cnt_q == 8'h00) begin
            dg_q            <= pswi_pkg::DG_RUN;
            autoneg_restart <= 1'b1;
          end else begin
            dg_cnt_q <= dg_cnt_q - 8'h01;
          end
        end
        default: dg_q <= pswi_pkg::DG_RUN;
      endcase
    end
  end

  assign pll_power_on  = dg_q != pswi_pkg::DG_DEEP;
  assign phy_supply_on = dg_q != pswi_pkg::DG_DEEP;

  deep_strap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    dg_q == pswi_pkg::DG_DEEP |-> uc_en_q && ctrl_q[pswi_pkg::PWR_DLL_BIT])
    else $error("Deep power-down without strap or enables.");

  sequence energy_in_deep_s;
    dg_q == pswi_pkg::DG_DEEP && |energy_q;
  endsequence

  deep_wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
    energy_in_deep_s |=> pll_power_on ##[1:DG_WIN] autoneg_restart)
    else $error("Negotiation not restarted after energy.");

  // ----------------------------------------------------------------
  // Low-power idle per MAC
  // ----------------------------------------------------------------
  for (genvar i = 0; i < pswi_pkg::NPORT; i++) begin : g_lpi
    pswi_pkg::pswi_lpi_t st_q;
    logic [15:0]         cnt_q;
    logic                ok;

    assign ok = lpi_en_q[i] && lp_lpi_cap[i]
                && (i < pswi_pkg::NCU || port_gmii[(i < pswi_pkg::NCU) ? 0 : i - 5]);

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        st_q            <= pswi_pkg::LPI_ACTIVE;
        cnt_q           <= 16'h0000;
        tx_sleep_sym[i] <= 1'b0;
        tx_wake_sym[i]  <= 1'b0;
      end else begin
        tx_sleep_sym[i] <= 1'b0;
        tx_wake_sym[i]  <= 1'b0;
        case (st_q)
          pswi_pkg::LPI_ACTIVE: begin
            if (ok && !txq_pending[i]) begin
              st_q  <= pswi_pkg::LPI_DELAY;
              cnt_q <= (buf_occupancy < lpi_thr_q) ? sleep_q[15:0] : sleep_q[31:16];
            end
          end
          pswi_pkg::LPI_DELAY: begin
            if (!ok || txq_pending[i]) begin
              st_q <= pswi_pkg::LPI_ACTIVE;
            end else if (cnt_q == 16'h0000) begin
              st_q            <= pswi_pkg::LPI_SLEEP;
              cnt_q           <= times_q[15:0];
              tx_sleep_sym[i] <= 1'b1;
            end else begin
              cnt_q <= cnt_q - 16'h0001;
            end
          end
          pswi_pkg::LPI_SLEEP: begin
            if (cnt_q != 16'h0000) begin
              cnt_q <= cnt_q - 16'h0001;
            end else if (txq_pending[i] || !ok) begin
              st_q           <= pswi_pkg::LPI_WAKE;
              cnt_q          <= times_q[31:16];
              tx_wake_sym[i] <= 1'b1;
            end
          end
          pswi_pkg::LPI_WAKE: begin
            if (cnt_q == 16'h0000) st_q <= pswi_pkg::LPI_ACTIVE;
            else cnt_q <= cnt_q - 16'h0001;
          end
          default: st_q <= pswi_pkg::LPI_ACTIVE;
        endcase
      end
    end

    assign tx_lpi[i] = st_q == pswi_pkg::LPI_SLEEP;
  end

  lpi_gmii_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_lpi[5] |-> port_gmii[0] || $past(port_gmii[0]))
    else $error("Port 5 idle without gigabit mode.");

  sleep_sym_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(tx_lpi[0]) |-> tx_sleep_sym[0] ##1 !tx_sleep_sym[0])
    else $error("Idle entered without one sleep symbol.");

  // ----------------------------------------------------------------
  // Short-cable diagnostics
  // ----------------------------------------------------------------
  // schedule, measure, reduce
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      diag_start   <= 5'h00;
      rx_power_low <= 5'h00;
    end else begin
      diag_start <= sc_q[4:0] & ({5{sc_q[pswi_pkg::SC_LINK_BIT-8] & 1'b0}}
                    | ((link_q[4:0] & ~link_prev_q[4:0]) & {5{sc_q[15]}}) | {5{sc_now}});
      for (int i = 0; i < pswi_pkg::NCU; i++) begin
        if (diag_done[i]) rx_power_low[i] <= diag_len < sc_q[15:8];
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupts and packet hold
  // ----------------------------------------------------------------
  logic [pswi_pkg::TICK_W-1:0] tick_q;
  logic [15:0]                 stat_set, stat_clr;
  logic [1:0]                  wake_ev;

  always_ff @(posedge aclk) begin
    if (!aresetn) tick_q <= '0;
    else if (tick_q == pswi_pkg::TICK_W'(pswi_pkg::TICK_CYC - 1)) tick_q <= '0;
    else tick_q <= tick_q + 1'b1;
  end

  for (genvar j = 0; j < 2; j++) begin : g_hold
    logic [15:0] cnt_q;
    logic        prev_q;

    assign wake_ev[j] = txq_pending[5+j] && !prev_q && int_en_q[pswi_pkg::INT_WAKE_LSB+5+j];

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cnt_q  <= 16'h0000;
        prev_q <= 1'b0;
      end else begin
        prev_q <= txq_pending[5+j];
        if (wake_ev[j]) cnt_q <= hold_time_q[j];
        else if (cnt_q != 16'h0000 && tick_q == '0) cnt_q <= cnt_q - 16'h0001;
      end
    end

    assign tx_hold[j] = cnt_q != 16'h0000;
  end

  assign stat_set = {1'b0, wake_ev, 6'h00, int_en_q[6:0] & (link_q ^ link_prev_q)};
  assign stat_clr = (wr_fire && awaddr == pswi_pkg::ADDR_INT_STAT)
                    ? 16'(wmerge(32'h0, wdata, wstrb)) : 16'h0000;

  // write one to clear, set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= pswi_pkg::RST_16;
      irq    <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~stat_clr) | stat_set;
      irq    <= |(stat_q & int_en_q);
    end
  end

  link_int_a: assert property (@(posedge aclk) disable iff (!aresetn)
    |(int_en_q[6:0] & (link_q ^ link_prev_q)) |=> |stat_q[6:0] ##1 irq)
    else $error("Link change on enabled port not flagged.");

  wake_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wake_ev[0] && hold_time_q[0] != 16'h0000 |=> tx_hold[0] && stat_q[13])
    else $error("Port 5 wake did not hold packets.");

  hold_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_hold[1] && g_hold[1].cnt_q > 16'h0001 |=> tx_hold[1])
    else $error("Management hold released early.");

  irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    stat_q[0] && int_en_q[0] && stat_clr[0] == 1'b0 |=> stat_q[0] && irq)
    else $error("Interrupt not held while status set.");

endmodule : pswi_top

`default_nettype wire

/* File: core/pswi_fix_note.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* File: verification/pswi_phy_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pswi_phy_model (
  // Clock
  input  wire logic       aclk,
  // Cable diagnostics
  input  wire logic [4:0] diag_start,
  output logic      [4:0] diag_done,
  output logic      [7:0] diag_len
);
  // ----------------------------------------------------------------
  // Cable test responder
  // ----------------------------------------------------------------
  // length answered one cycle after start; idle length toggles so stale data is not reused.
  always @(posedge aclk) begin
    diag_done <= diag_start;
    diag_len  <= (diag_start != 5'h00) ? 8'h0a : ~diag_len;
  end
endmodule : pswi_phy_model
`default_nettype wire

/* File: verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ----------------------------------------------------------------
  // Bench
  // ----------------------------------------------------------------
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic [1:0] r;} pswi_row_t;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, uc_en_strap = 1'b1, probe;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, buf_occupancy = 8'h00, diag_len;
  logic [31:0] wdata = 32'h0000_0000, rdata, got;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] port_gmii = 2'h3, sel = 2'h0, bresp, rresp, tx_hold, rsp;
  logic [6:0] link_up_pin = 7'h00, txq_pending = 7'h00, lp_lpi_cap = 7'h7f;
  logic [6:0] tx_lpi, tx_sleep_sym, tx_wake_sym;
  logic [4:0] energy_pin = 5'h00, phy_power_down, diag_start, diag_done, rx_power_low;
  logic awready, wready, bvalid, arready, rvalid, irq, phy_supply_on, pll_power_on, autoneg_restart;
  int n_errors = 0;
  int tests_run = 0;
  pswi_row_t rows [4] = '{
    '{8'h08, 32'h0000_ffff, {16'h0, pswi_pkg::INT_EN_MASK}, 2'h0},
    '{8'h10, 32'h0000_1234, 32'h0000_1234, 2'h0},
    '{8'h14, 32'h0000_0003, 32'h0000_0003, 2'h0},
    '{8'h0c, 32'h0000_0001, 32'h0000_0000, 2'h2}};
  always #25 aclk = ~aclk;
  always_comb probe = (sel == 2'h0) ? irq : (sel == 2'h1) ? phy_power_down[1] : tx_hold[1];
  pswi_top #(.APD_SHORT_CYC(50), .APD_LONG_CYC(100)) DUT (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .link_up_pin, .energy_pin, .uc_en_strap, .phy_power_down, .phy_supply_on,
    .pll_power_on, .autoneg_restart, .txq_pending, .buf_occupancy, .lp_lpi_cap,
    .port_gmii, .tx_lpi, .tx_sleep_sym, .tx_wake_sym, .tx_hold, .diag_start,
    .diag_done, .diag_len, .rx_power_low, .irq);
  pswi_phy_model PHY (.aclk, .diag_start, .diag_done, .diag_len);
  task automatic final_report;
    if (n_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] a);
    tests_run++;
    if (a !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, a);
    end
  endtask : chk
  task automatic tmo(input int i);
    if (i >= 20) begin
      n_errors++;
      final_report();
    end
  endtask : tmo
  // Waits a bounded time for the selected output to reach a level.
  task automatic await(input logic [1:0] s, input logic v, input int lim, input string nm);
    int i;
    sel = s;
    for (i = 0; i < lim && probe !== v; i++) begin
      @(posedge aclk);
      #1;
    end
    chk(nm, {31'h0, v}, {31'h0, probe});
    if (probe !== v) final_report();
  endtask : await
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 20 && !(awready && wready && awvalid); i++) @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    for (i = 0; i < 20 && bvalid !== 1'b1; i++) @(posedge aclk);
    rsp = bresp;
    bready <= 1'b0;
    tmo(i);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 20 && !(arready && arvalid); i++) @(posedge aclk);
    arvalid <= 1'b0;
    for (i = 0; i < 20 && rvalid !== 1'b1; i++) @(posedge aclk);
    got = rdata;
    rsp = rresp;
    rready <= 1'b0;
    tmo(i);
  endtask : rd
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[k]) begin
      wr(rows[k].a, rows[k].d);
      chk("bresp", {30'h0, rows[k].r}, {30'h0, rsp});
      rd(rows[k].a);
      chk("rdata", rows[k].q, got);
      chk("rresp", {30'h0, rows[k].r}, {30'h0, rsp});
    end
    wr(8'h08, 32'h0000_0001);
    link_up_pin <= 7'h04;
    repeat (6) @(posedge aclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(8'h18, 32'h0000_ffff);
    link_up_pin <= 7'h05;
    await(2'h0, 1'b1, 8, "irq link");
    rd(8'h18);
    chk("status", 32'h0000_0001, got);
    wr(8'h18, 32'h0000_0001);
    await(2'h0, 1'b0, 4, "irq clear");
    // wake interrupt holds the queue for two 20-cycle ticks (21 to 40 cycles)
    wr(8'h08, 32'h0000_4000);
    wr(8'h10, 32'h0000_0002);
    txq_pending <= 7'h40;
    await(2'h2, 1'b1, 4, "hold on");
    await(2'h0, 1'b1, 4, "irq wake");
    repeat (15) @(posedge aclk);
    chk("held", 32'h1, {31'h0, tx_hold[1]});
    await(2'h2, 1'b0, 30, "hold off");
    // power-down, periodic check, back to sleep
    wr(8'h00, 32'h0000_0002);
    await(2'h1, 1'b1, 8, "apd down");
    await(2'h1, 1'b0, 60, "apd check");
    await(2'h1, 1'b1, 2100, "apd resleep");
    aresetn <= 1'b0;
    uc_en_strap <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h08);
    chk("int_en reset", 32'h0, got);
    rd(8'h2c);
    chk("status strap", 32'h0000_0005, got);
    chk("irq reset", 32'h0, {31'h0, irq});
    final_report();
  end
endmodule : tb
`default_nettype wire
